// >>> pkg/ppb_pkg.sv
// Constants for the parallel port bank: register map, masks, reset values
package ppb_pkg;

    // ************************************************************
    // Register indices; byte address is four times the index
    // ************************************************************
    localparam logic [3:0] IDX_A_DATA = 4'h0;
    localparam logic [3:0] IDX_B_DATA = 4'h1;
    localparam logic [3:0] IDX_C_DATA = 4'h2;
    localparam logic [3:0] IDX_D_DATA = 4'h3;
    localparam logic [3:0] IDX_A_DIR = 4'h4;
    localparam logic [3:0] IDX_B_DIR = 4'h5;
    localparam logic [3:0] IDX_C_DIR = 4'h6;
    localparam logic [3:0] IDX_D_DIR = 4'h7;
    localparam logic [3:0] IDX_E_DATA = 4'h8;
    localparam logic [3:0] IDX_F_DATA = 4'h9;
    localparam logic [3:0] IDX_G_DATA = 4'hA;
    localparam logic [3:0] IDX_H_DATA = 4'hB;
    localparam logic [3:0] IDX_E_DIR = 4'hC;
    localparam logic [3:0] IDX_F_DIR = 4'hD;
    localparam logic [3:0] IDX_G_DIR = 4'hE;
    localparam logic [3:0] IDX_H_DIR = 4'hF;

    // Per port lookup, port A in slice 0 up to port H in slice 7
    localparam logic [7:0][3:0] DATA_IDX = {IDX_H_DATA, IDX_G_DATA,
        IDX_F_DATA, IDX_E_DATA, IDX_D_DATA, IDX_C_DATA, IDX_B_DATA,
        IDX_A_DATA};
    localparam logic [7:0][3:0] DIR_IDX = {IDX_H_DIR, IDX_G_DIR,
        IDX_F_DIR, IDX_E_DIR, IDX_D_DIR, IDX_C_DIR, IDX_B_DIR,
        IDX_A_DIR};

    // ************************************************************
    // Implemented bits per port
    // ************************************************************
    localparam logic [7:0][7:0] BIT_MASK = {8'h03, 8'h07, 8'h7F, 8'hFF,
        8'hFF, 8'h3F, 8'hFF, 8'hFF};

    // ************************************************************
    // Port numbers, field positions, reset values
    // ************************************************************
    localparam int PORT_A = 0;
    localparam int PORT_B = 1;
    localparam int PORT_C = 2;
    localparam int PORT_F = 5;
    localparam int PORT_COUNT = 8;
    localparam int PORT_WIDTH = 8;
    localparam int SYSCLK_EN_BIT = 7;
    localparam int SYSCLK_PIN = 2;
    localparam int ADDR_IDX_LSB = 2;
    localparam int CH_WIDTH = 5;
    localparam logic [7:0] DIR_RESET = 8'h00;
    localparam logic SYSCLK_EN_RESET = 1'b0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

endpackage

// >>> core/ppb_top.sv
// Parallel port bank: eight byte ports with APB register access
// ************************************************************
// Summary of operation
// - Direction bit one drives latch onto port A pin; zero leaves input.
// - Reset clears port A direction, all pins input.
// - Reset leaves port A data latches untouched.
// - Port A read gives latch for outputs, pin level for inputs.
// - Data writes with ce and pstrb[0] high update latches whatever the direction.
// - Port B has eight per-bit directions, cleared on reset, latches kept.
// - Non-converter port B read gives latch or pin by direction.
// - Converter channel select picks which port B pin is analog.
// - Converter pin read gives zero as input, latch as output.
// - Converter pin direction bit leaves output buffer off.
// - Port C has six bits; data bits 7 and 6 read zero.
// - Unused bits of ports F, G and H read zero.
// - Port C direction bit 7 is clock-out enable, bit 6 zero.
// - Clock-out enable drives clock on port C pin 2; reset clears it.
// ************************************************************
`timescale 1ns/1ps
`default_nettype none

module ppb_top (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins, port A in bits 7:0 up to port H in bits 63:56
    input wire logic [63:0] pin_in,
    output logic [63:0] pin_out,
    output logic [63:0] pin_oe,
    // Converter side
    input wire logic [4:0] converter_channel_select,
    output logic [7:0] converter_inputs
);

    // ************************************************************
    // APB decode
    // ************************************************************
    logic [3:0] idx;
    logic mapped;
    logic setup;
    logic access;
    logic wr_lane;

    assign idx = paddr[ppb_pkg::ADDR_IDX_LSB +: 4];
    assign mapped = (paddr[7:6] == 2'h0) && (paddr[1:0] == 2'h0);
    assign setup = psel && !penable;
    assign access = psel && penable;
    // Only byte lane 0 carries register bits
    assign wr_lane = access && pwrite && pstrb[0] && mapped && ce;
    // Read data is captured in setup, so every access completes at once
    assign pready = access;
    assign pslverr = access && !mapped;

    // ************************************************************
    // Converter pin selection
    // ************************************************************
    logic [7:0] adc_pin;

    // Channel codes 0..7 land on port B; higher codes leave it alone
    assign adc_pin = (converter_channel_select[4:3] == 2'h0) ?
        (8'h01 << converter_channel_select[2:0]) : 8'h00;

    // ************************************************************
    // Per port latch, direction, synchroniser
    // ************************************************************
    logic [7:0] latch [8];
    logic [7:0] dir [8];
    logic [7:0] sync1 [8];
    logic [7:0] sync2 [8];
    logic [7:0] rd_val [8];
    logic [7:0] wr_data [8];
    logic [7:0] wr_dir [8];
    logic sysclk_out_enable;

    genvar p;
    generate
        for (p = 0; p < ppb_pkg::PORT_COUNT; p++) begin : g_port
            localparam logic [7:0] MSK = ppb_pkg::BIT_MASK[p];
            logic [7:0] analog;
            logic [7:0] pad;
            logic [7:0] oe;
            logic hit_data;
            logic hit_dir;

            assign analog = (p == ppb_pkg::PORT_B) ? adc_pin : 8'h00;
            assign pad = pin_in[8*p +: 8];
            assign hit_data = wr_lane && (idx == ppb_pkg::DATA_IDX[p]);
            assign hit_dir = wr_lane && (idx == ppb_pkg::DIR_IDX[p]);
            assign wr_data[p] = pwdata[7:0] & MSK;
            assign wr_dir[p] = pwdata[7:0] & MSK;

            // Latches have no reset term, contents survive reset
            always_ff @(posedge pclk) begin
                if (hit_data) begin
                    latch[p] <= wr_data[p];
                end
            end

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    dir[p] <= ppb_pkg::DIR_RESET;
                end else if (hit_dir) begin
                    dir[p] <= wr_dir[p];
                end
            end

            // Two stages against metastable pin levels
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1[p] <= 8'h00;
                    sync2[p] <= 8'h00;
                end else if (ce) begin
                    sync1[p] <= pad;
                    sync2[p] <= sync1[p];
                end
            end

            // Inputs read the pin, except converter pins which read zero
            assign rd_val[p] = MSK & ((dir[p] & latch[p]) |
                (~dir[p] & ~analog & sync2[p]));

            // Converter pins keep the buffer off whatever direction says
            assign oe = dir[p] & ~analog & MSK;

            if (p == ppb_pkg::PORT_C) begin : g_clk
                assign pin_oe[8*p +: 8] = oe |
                    ({7'h00, sysclk_out_enable} << ppb_pkg::SYSCLK_PIN);
                // Clock goes straight out; it is not a data path
                assign pin_out[8*p +: 8] = sysclk_out_enable ?
                    ((latch[p] & MSK & ~(8'h01 << ppb_pkg::SYSCLK_PIN)) |
                    ({7'h00, pclk} << ppb_pkg::SYSCLK_PIN)) :
                    (latch[p] & MSK);
            end else begin : g_plain
                assign pin_oe[8*p +: 8] = oe;
                assign pin_out[8*p +: 8] = latch[p] & MSK;
            end
        end
    endgenerate

    assign converter_inputs = sync2[ppb_pkg::PORT_B];

    // ************************************************************
    // Clock-out enable in port C direction bit 7
    // ************************************************************
    logic hit_cdir;

    assign hit_cdir = wr_lane && (idx == ppb_pkg::IDX_C_DIR);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysclk_out_enable <= ppb_pkg::SYSCLK_EN_RESET;
        end else if (hit_cdir) begin
            sysclk_out_enable <= pwdata[ppb_pkg::SYSCLK_EN_BIT];
        end
    end

    // ************************************************************
    // Read path, registered in the setup cycle
    // ************************************************************
    logic [7:0] sel_val;
    logic [7:0] next_byte;
    logic [31:0] next_prdata;

    always_comb begin
        sel_val = 8'h00;
        for (int i = 0; i < ppb_pkg::PORT_COUNT; i++) begin
            if (idx == ppb_pkg::DATA_IDX[i]) begin
                sel_val = rd_val[i];
            end
            if (idx == ppb_pkg::DIR_IDX[i]) begin
                sel_val = dir[i];
            end
        end
    end

    assign next_byte = (idx == ppb_pkg::IDX_C_DIR) ?
        (sel_val | {sysclk_out_enable, 7'h00}) : sel_val;
    assign next_prdata = mapped ? {24'h000000, next_byte} :
        ppb_pkg::READ_ZERO;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= ppb_pkg::READ_ZERO;
        end else if (ce && setup && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    logic rd_setup;

    assign rd_setup = ce && setup && !pwrite && mapped;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    property p_oe_dir;
        pin_oe[7:0] == dir[ppb_pkg::PORT_A];
    endproperty
    a_oe_dir: assert property (p_oe_dir)
        else $error("port A enable differs from direction");

    property p_dir_reset;
        $rose(presetn) |-> (dir[ppb_pkg::PORT_A] == 8'h00) &&
            (dir[ppb_pkg::PORT_B] == 8'h00) && !sysclk_out_enable;
    endproperty
    a_dir_reset: assert property (p_dir_reset)
        else $error("direction not cleared by reset");

    property p_latch_write;
        (wr_lane && idx == ppb_pkg::IDX_A_DATA) |=>
            latch[ppb_pkg::PORT_A] == $past(pwdata[7:0]);
    endproperty
    a_latch_write: assert property (p_latch_write)
        else $error("port A latch missed a write");

    property p_read_a;
        (rd_setup && idx == ppb_pkg::IDX_A_DATA) |=>
            prdata[7:0] == $past((dir[0] & latch[0]) | (~dir[0] & sync2[0]));
    endproperty
    a_read_a: assert property (p_read_a)
        else $error("port A read value wrong");

    property p_adc_read;
        (rd_setup && idx == ppb_pkg::IDX_B_DATA) |=>
            (prdata[7:0] & $past(adc_pin & ~dir[ppb_pkg::PORT_B])) == 8'h00;
    endproperty
    a_adc_read: assert property (p_adc_read)
        else $error("converter pin read not zero");

    property p_adc_oe;
        (pin_oe[15:8] & adc_pin) == 8'h00;
    endproperty
    a_adc_oe: assert property (p_adc_oe)
        else $error("converter pin buffer enabled");

    property p_c_top;
        (rd_setup && idx == ppb_pkg::IDX_C_DATA) |=> prdata[7:6] == 2'h0;
    endproperty
    a_c_top: assert property (p_c_top)
        else $error("port C top bits not zero");

    property p_f_top;
        (rd_setup && (idx == ppb_pkg::IDX_F_DATA ||
            idx == ppb_pkg::IDX_F_DIR)) |=> prdata[7] == 1'b0;
    endproperty
    a_f_top: assert property (p_f_top)
        else $error("port F bit 7 not zero");

    property p_clk_oe;
        sysclk_out_enable |-> pin_oe[18];
    endproperty
    a_clk_oe: assert property (p_clk_oe)
        else $error("clock pin not driven");

    // Skip the edge just after reset: the first stage still held zero
    property p_sync;
        (ce && $past(ce) && $past(presetn)) |=>
            sync2[0] == $past(pin_in[7:0], 2);
    endproperty
    a_sync: assert property (p_sync)
        else $error("pin synchroniser delay wrong");

    // ************************************************************
    // Checks on pin drive, stored state and read-back
    // ************************************************************
    property p_b_oe_input;
        (pin_oe[15:8] & ~dir[ppb_pkg::PORT_B]) == 8'h00;
    endproperty
    a_b_oe_input: assert property (p_b_oe_input)
        else $error("port B input pin driven");

    // No channel on port B: buffers follow direction alone
    property p_adc_free;
        (converter_channel_select[4:3] != 2'h0) |->
            pin_oe[15:8] == dir[ppb_pkg::PORT_B];
    endproperty
    a_adc_free: assert property (p_adc_free)
        else $error("port B buffer blocked without channel");

    property p_dir_write;
        (wr_lane && idx == ppb_pkg::IDX_A_DIR) |=>
            dir[ppb_pkg::PORT_A] == $past(pwdata[7:0]);
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("port A direction missed a write");

    // Direction changes only through the bus
    property p_dir_hold;
        !wr_lane |=> dir[ppb_pkg::PORT_A] == $past(dir[ppb_pkg::PORT_A]);
    endproperty
    a_dir_hold: assert property (p_dir_hold)
        else $error("port A direction changed without a write");

    property p_b_latch_write;
        (wr_lane && idx == ppb_pkg::IDX_B_DATA) |=>
            latch[ppb_pkg::PORT_B] == $past(pwdata[7:0]);
    endproperty
    a_b_latch_write: assert property (p_b_latch_write)
        else $error("port B latch missed a write");

    property p_c_store;
        (wr_lane && idx == ppb_pkg::IDX_C_DATA) |=>
            latch[ppb_pkg::PORT_C][7:6] == 2'h0;
    endproperty
    a_c_store: assert property (p_c_store)
        else $error("port C stored a read-zero bit");

    // Plain input bits of port B read the synchronised pin
    property p_read_b_in;
        (rd_setup && idx == ppb_pkg::IDX_B_DATA) |=>
            ((prdata[7:0] ^ $past(sync2[ppb_pkg::PORT_B])) &
            $past(~dir[ppb_pkg::PORT_B] & ~adc_pin)) == 8'h00;
    endproperty
    a_read_b_in: assert property (p_read_b_in)
        else $error("port B input bit read wrong");

    property p_read_b_out;
        (rd_setup && idx == ppb_pkg::IDX_B_DATA) |=>
            ((prdata[7:0] ^ $past(latch[ppb_pkg::PORT_B])) &
            $past(dir[ppb_pkg::PORT_B])) == 8'h00;
    endproperty
    a_read_b_out: assert property (p_read_b_out)
        else $error("port B output bit read wrong");

    property p_c_dir_top;
        (rd_setup && idx == ppb_pkg::IDX_C_DIR) |=>
            prdata[7:6] == {$past(sysclk_out_enable), 1'b0};
    endproperty
    a_c_dir_top: assert property (p_c_dir_top)
        else $error("port C direction top bits wrong");

    property p_g_top;
        (rd_setup && (idx == ppb_pkg::IDX_G_DATA ||
            idx == ppb_pkg::IDX_G_DIR)) |=> prdata[7:3] == 5'h00;
    endproperty
    a_g_top: assert property (p_g_top)
        else $error("port G top bits not zero");

    property p_h_top;
        (rd_setup && (idx == ppb_pkg::IDX_H_DATA ||
            idx == ppb_pkg::IDX_H_DIR)) |=> prdata[7:2] == 6'h00;
    endproperty
    a_h_top: assert property (p_h_top)
        else $error("port H top bits not zero");

    property p_c_oe_plain;
        !sysclk_out_enable |-> pin_oe[23:16] == dir[ppb_pkg::PORT_C];
    endproperty
    a_c_oe_plain: assert property (p_c_oe_plain)
        else $error("port C buffer wrong with clock out off");

    property p_en_write;
        hit_cdir |=>
            sysclk_out_enable == $past(pwdata[ppb_pkg::SYSCLK_EN_BIT]);
    endproperty
    a_en_write: assert property (p_en_write)
        else $error("clock-out enable missed a write");

    // Low enable freezes synchroniser and read data
    property p_ce_freeze;
        !ce |=> (sync2[ppb_pkg::PORT_A] ==
            $past(sync2[ppb_pkg::PORT_A])) && (prdata == $past(prdata));
    endproperty
    a_ce_freeze: assert property (p_ce_freeze)
        else $error("state moved while enable low");

endmodule // ppb_top

`default_nettype wire

// >>> test/ppb_pin_model.sv
// Pin-side partner: resolves each pad from device drive or outside level
`timescale 1ns/1ps
`default_nettype none

module ppb_pin_model (
    // Device pad side
    input wire logic [63:0] pin_out,
    input wire logic [63:0] pin_oe,
    // Level from outside parts while a pad is released
    input wire logic [63:0] ext_level,
    output logic [63:0] pin_in
);
    // A driven pad shows the device value, never a stale outside level
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // ppb_pin_model

`default_nettype wire

// >>> test/ppb_top_tb_top.sv
// Self-checking bench for the parallel port bank
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin \
    errors++; $display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end

module ppb_top_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, rd_v, conv_in;
    logic [31:0] pwdata, prdata;
    logic [63:0] pin_in, pin_out, pin_oe, ext;
    logic [4:0] chsel;
    logic [3:0] pstrb;
    logic ce;
    logic err_v;
    int errors, samples_checked;

    ppb_top dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .converter_channel_select(chsel), .converter_inputs(conv_in));
    ppb_pin_model pins_u (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_level(ext), .pin_in(pin_in));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ************************************************************
    // Bus and closing tasks
    // ************************************************************
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            errors++;
            test_done;
        end
        rd_v = prdata[7:0];
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [3:0] i, input logic [7:0] d);
        apb(1'b1, {2'b00, i, 2'b00}, d);
    endtask

    task automatic rd(input logic [3:0] i);
        apb(1'b0, {2'b00, i, 2'b00}, 8'h00);
    endtask

    // Synchroniser needs two edges; four leave margin
    task automatic settle;
        repeat (4) @(posedge pclk);
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_port_a;
        ext[7:0] <= 8'h3C;
        wr(ppb_pkg::IDX_A_DATA, 8'hA5);
        wr(ppb_pkg::IDX_A_DIR, 8'h00);
        settle;
        rd(ppb_pkg::IDX_A_DATA);
        `CHK("a_in", 8'h3C, rd_v)
        wr(ppb_pkg::IDX_A_DIR, 8'h0F);
        settle;
        `CHK("a_oe", 8'h0F, pin_oe[7:0])
        `CHK("a_out", 4'h5, pin_out[3:0])
        rd(ppb_pkg::IDX_A_DATA);
        `CHK("a_mix", 8'h35, rd_v)
        $display("done port_a");
    endtask

    task automatic t_reset;
        wr(ppb_pkg::IDX_A_DATA, 8'h5A);
        wr(ppb_pkg::IDX_C_DIR, 8'h80);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        settle;
        `CHK("rst_oe", 64'h0, pin_oe)
        rd(ppb_pkg::IDX_A_DIR);
        `CHK("rst_dir", 8'h00, rd_v)
        rd(ppb_pkg::IDX_C_DIR);
        `CHK("rst_cdir", 8'h00, rd_v)
        wr(ppb_pkg::IDX_A_DIR, 8'hFF);
        rd(ppb_pkg::IDX_A_DATA);
        `CHK("rst_latch", 8'h5A, rd_v)
        $display("done reset");
    endtask

    task automatic t_port_b;
        chsel <= 5'h03;
        ext[15:8] <= 8'hFF;
        wr(ppb_pkg::IDX_B_DATA, 8'h0F);
        wr(ppb_pkg::IDX_B_DIR, 8'hFF);
        settle;
        `CHK("b_oe", 8'hF7, pin_oe[15:8])
        rd(ppb_pkg::IDX_B_DATA);
        `CHK("b_out", 8'h0F, rd_v)
        wr(ppb_pkg::IDX_B_DIR, 8'h00);
        settle;
        rd(ppb_pkg::IDX_B_DATA);
        `CHK("b_in", 8'hF7, rd_v)
        chsel <= 5'h08;
        settle;
        rd(ppb_pkg::IDX_B_DATA);
        `CHK("b_gpio", 8'hFF, rd_v)
        `CHK("b_conv", 8'hFF, conv_in)
        $display("done port_b");
    endtask

    task automatic t_port_c;
        wr(ppb_pkg::IDX_C_DATA, 8'hFF);
        wr(ppb_pkg::IDX_C_DIR, 8'hFF);
        settle;
        rd(ppb_pkg::IDX_C_DATA);
        `CHK("c_data", 8'h3F, rd_v)
        rd(ppb_pkg::IDX_C_DIR);
        `CHK("c_dir", 8'hBF, rd_v)
        wr(ppb_pkg::IDX_C_DIR, 8'h80);
        settle;
        `CHK("c_clk_oe", 8'h04, pin_oe[23:16])
        #1;
        `CHK("c_clk_hi", 1'b1, pin_out[18])
        @(negedge pclk);
        #1;
        `CHK("c_clk_lo", 1'b0, pin_out[18])
        $display("done port_c");
    endtask

    task automatic t_masks;
        for (int p = ppb_pkg::PORT_F; p < ppb_pkg::PORT_COUNT; p++) begin
            wr(ppb_pkg::DATA_IDX[p], 8'hFF);
            wr(ppb_pkg::DIR_IDX[p], 8'hFF);
            rd(ppb_pkg::DIR_IDX[p]);
            `CHK("hi_dir", ppb_pkg::BIT_MASK[p], rd_v)
            rd(ppb_pkg::DATA_IDX[p]);
            `CHK("hi_data", ppb_pkg::BIT_MASK[p], rd_v)
        end
        apb(1'b1, 8'h40, 8'hFF);
        `CHK("unmap_w", 1'b1, err_v)
        apb(1'b0, 8'h40, 8'h00);
        `CHK("unmap_r", 8'h00, rd_v)
        $display("done masks");
    endtask

    // Refused writes and a frozen clock enable
    task automatic t_gating;
        pstrb <= 4'hE;
        wr(ppb_pkg::IDX_A_DATA, 8'h11);
        pstrb <= 4'hF;
        ce <= 1'b0;
        ext[15:8] <= 8'h00;
        wr(ppb_pkg::IDX_A_DATA, 8'h22);
        settle;
        `CHK("ce_conv", 8'hFF, conv_in)
        ce <= 1'b1;
        settle;
        `CHK("ce_conv2", 8'h00, conv_in)
        rd(ppb_pkg::IDX_A_DATA);
        `CHK("gate_latch", 8'h5A, rd_v)
        $display("done gating");
    endtask

    initial begin
        errors = 0;
        samples_checked = 0;
        presetn = 1'b0;
        {psel, penable, pwrite} = 3'b000;
        paddr = 8'h00;
        pwdata = 32'h00000000;
        chsel = 5'h1F;
        ce = 1'b1;
        pstrb = 4'hF;
        ext = 64'h0000_0000_0000_0000;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_port_a;
        t_reset;
        t_port_b;
        t_port_c;
        t_masks;
        t_gating;
        test_done;
    end
endmodule // ppb_top_tb_top

`default_nettype wire
